// [hdl/irq_chain_regs.svh]
`ifndef IRQ_CHAIN_REGS_SVH
`define IRQ_CHAIN_REGS_SVH

// Word indices on the register bus
`define LOCAL_VEC_IDX    4'h0
`define BUS_VEC_IDX      4'h1
`define LOCAL_STAT_IDX   4'h2
`define LOCAL_MASK_IDX   4'h3
`define BUS_STAT_IDX     4'h4
`define BUS_MASK_IDX     4'h5
`define LOCAL_LVL_IDX    4'h6
`define VME_EN_IDX       4'h7
`define CHAIN_STAT_IDX   4'h8

// Printed device addresses of the two vector registers
`define LOCAL_VEC_ADDR   32'hfffe102d
`define BUS_VEC_ADDR     32'hfffe2013

// Reset values
`define LOCAL_VEC_RST    8'h00
`define BUS_VEC_RST      8'h00
`define LOCAL_LVL_RST    27'h0000000
`define VME_EN_RST       7'h00

// Vector field layout
`define LOCAL_BASE_MSB   7
`define LOCAL_BASE_LSB   4
`define BUS_BASE_MSB     7
`define BUS_BASE_LSB     3

// Interrupt acknowledge decode and fixed source levels
`define IACK_FC          3'h7
`define IACK_ADDR_HI     4'hf
`define FIXED_LEVEL      3'h7
`define FIXED_LEVELS     9'h1ff

`endif

// [hdl/irq_chain_pkg.sv]
package irq_chain_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CHAIN,
		ST_VME_ARB,
		ST_VME_IACK,
		ST_DONE
	} ack_state_t;

	typedef struct packed {
		ack_state_t  st;
		logic [2:0]  lvl;
		logic [7:0]  vec;
		logic        ack_out;
		logic [2:0]  ipl_n;
		logic        irq;
		logic [31:0] rdata;
		logic        waitreq;
		logic [7:0]  dout;
		logic        doe_n;
		logic        dtack_n;
		logic        vme_req;
		logic        vme_iack;
		logic [2:0]  vme_lvl;
		logic [7:0]  lbase;
		logic [7:0]  bbase;
		logic [26:0] lvl_cfg;
		logic [6:0]  vme_en;
		logic [1:0]  last_src;
	} chain_regs_t;

endpackage

// [hdl/irq_level_pick.sv]
`timescale 1ns/1ps
module irq_level_pick import irq_chain_pkg::*; #(
	parameter int N = 12
) (
	input  wire logic [N-1:0]         pend,    // Enabled pending sources
	input  wire logic [3*N-1:0]       lvls,    // Level of each source
	output logic      [2:0]           top_lvl, // Highest pending level
	output logic      [$clog2(N)-1:0] top_idx  // Lowest index at that level
);
	if (N < 2 || N > 16) begin : g_chk
		$error("irq_level_pick: N out of range");
	end

	always_comb begin
		top_lvl = 3'h0;
		top_idx = '0;
		// Strict compare, so the lowest index wins a tie
		for (int i = 0; i < N; i++) begin
			if (pend[i] && (lvls[3*i +: 3] > top_lvl)) begin
				top_lvl = lvls[3*i +: 3];
				top_idx = ($clog2(N))'(i);
			end
		end
	end
endmodule

// [hdl/irq_sticky_bank.sv]
`timescale 1ns/1ps
module irq_sticky_bank import irq_chain_pkg::*; #(
	parameter int W = 12
) (
	input  wire logic         ref_clk,  // Clock
	input  wire logic         rst,      // Sync reset, active high
	input  wire logic [W-1:0] src,      // Source levels
	input  wire logic         clr_we,   // Write-one-to-clear strobe
	input  wire logic         mask_we,  // Mask write strobe
	input  wire logic [W-1:0] wdata,    // Write data
	output logic      [W-1:0] status,   // Sticky status
	output logic      [W-1:0] mask,     // Enable mask
	output logic      [W-1:0] pending   // Status and mask
);
	if (W < 1 || W > 32) begin : g_chk
		$error("irq_sticky_bank: W out of range");
	end

	typedef struct packed {
		logic [W-1:0] status;
		logic [W-1:0] mask;
		logic [W-1:0] prev;
	} bank_t;

	bank_t r_reg;
	bank_t r_next;

	always_comb begin
		r_next = r_reg;
		r_next.prev = src;
		// Set beats clear: a new edge is never lost
		r_next.status = (r_reg.status & ~(clr_we ? wdata : '0))
			| (src & ~r_reg.prev);
		if (mask_we) begin
			r_next.mask = wdata; // [R1]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign status  = r_reg.status;
	assign mask    = r_reg.mask;
	assign pending = r_reg.status & r_reg.mask; // [R1]
endmodule

// [hdl/interrupt_ack_vector_chain.sv]
`timescale 1ns/1ps
`include "irq_chain_regs.svh"

// What this block does
// [R1] Every source has its own software enable
// [R2] Power fail, bus error, abort fixed level seven
// [R3] Acknowledge decoded from address and function code
// [R4] Local match gives vector, else chain onward
// [R5] Bus chip answers when requesting that level
// [R6] Otherwise win bus, run remote acknowledge cycle
// [R7] Remote interrupter supplies vector on that cycle
// [R8] Local beats bus chip beats remote lines
// [R9] Local vector: base nibble plus source code
// [R10] Bus chip vector: five base bits, code
// [R11] Abort switch raises level seven when enabled
// [R12] Vector on low byte, terminate, else release
module interrupt_ack_vector_chain import irq_chain_pkg::*; (
	input  wire logic        ref_clk,       // 100 MHz clock
	input  wire logic        rst,           // Sync reset, active high
	input  wire logic [3:0]  address,       // Avalon word address
	input  wire logic        read,          // Avalon read
	input  wire logic        write,         // Avalon write
	input  wire logic [31:0] writedata,     // Avalon write data
	output logic      [31:0] readdata,      // Avalon read data
	output logic             waitrequest,   // Avalon wait
	output logic             irq_out,       // Unmasked status pending
	input  wire logic [11:0] local_src,     // Local sources, bit 2 abort
	input  wire logic [6:0]  bus_src,       // Bus chip sources codes 1..7
	input  wire logic [6:0]  vme_irq,       // Remote lines levels 1..7
	input  wire logic        cpu_as_n,      // Core address strobe
	input  wire logic [2:0]  cpu_fc,        // Core function code
	input  wire logic [19:1] cpu_addr,      // Core address bus
	output logic      [2:0]  ipl_n,         // Level request to core
	output logic      [7:0]  cpu_data_o,    // Vector byte
	output logic             cpu_data_oe_n, // Low while driving
	output logic             cpu_dtack_n,   // Cycle termination
	output logic             chain_ack_out, // Acknowledge to bus chip
	input  wire logic        vme_bus_held,  // Remote bus already owned
	input  wire logic        vme_bus_grant, // Remote bus granted
	output logic             vme_bus_req,   // Remote bus request
	output logic             vme_iack,      // Remote acknowledge cycle
	output logic      [2:0]  vme_iack_lvl,  // Level being acknowledged
	input  wire logic [7:0]  vme_vector,    // Vector from remote slave
	input  wire logic        vme_dtack      // Remote slave answered
);
	localparam logic [20:0] SEQ_LVLS = {3'h7, 3'h6, 3'h5, 3'h4,
		3'h3, 3'h2, 3'h1};

	chain_regs_t r_reg;
	chain_regs_t r_next;

	logic [11:0] local_stat, local_mask, local_pend;
	logic [6:0]  bus_stat, bus_mask, bus_pend;
	logic [3:0]  local_idx;
	logic [2:0]  local_top, bus_top, bus_idx, vme_top, all_top, iack_lvl;
	logic        req, take, iack_hit;
	logic [31:0] rd_mux;

	// ==========================================================
	// Source banks and level priority
	// ==========================================================
	irq_sticky_bank #(.W(12)) u_local_bank (
		.ref_clk (ref_clk),
		.rst     (rst),
		.src     (local_src),
		.clr_we  (take && write && address == `LOCAL_STAT_IDX),
		.mask_we (take && write && address == `LOCAL_MASK_IDX),
		.wdata   (writedata[11:0]),
		.status  (local_stat),
		.mask    (local_mask),
		.pending (local_pend)
	);

	irq_sticky_bank #(.W(7)) u_bus_bank (
		.ref_clk (ref_clk),
		.rst     (rst),
		.src     (bus_src),
		.clr_we  (take && write && address == `BUS_STAT_IDX),
		.mask_we (take && write && address == `BUS_MASK_IDX),
		.wdata   (writedata[6:0]),
		.status  (bus_stat),
		.mask    (bus_mask),
		.pending (bus_pend)
	);

	// Sources 0..2 pinned to level seven [R2] [R11]
	irq_level_pick #(.N(12)) u_local_pick (
		.pend    (local_pend),
		.lvls    ({r_reg.lvl_cfg, `FIXED_LEVELS}),
		.top_lvl (local_top),
		.top_idx (local_idx)
	);

	// Bus chip level equals its source code [R10]
	irq_level_pick #(.N(7)) u_bus_pick (
		.pend    (bus_pend),
		.lvls    (SEQ_LVLS),
		.top_lvl (bus_top),
		.top_idx (bus_idx)
	);

	irq_level_pick #(.N(7)) u_vme_pick (
		.pend    (vme_irq & r_reg.vme_en),
		.lvls    (SEQ_LVLS),
		.top_lvl (vme_top),
		.top_idx ()
	);

	// ==========================================================
	// Decode
	// ==========================================================
	always_comb begin
		all_top = local_top;
		if (bus_top > all_top) begin
			all_top = bus_top;
		end
		if (vme_top > all_top) begin
			all_top = vme_top;
		end
	end

	assign req      = read || write;
	assign take     = req && !r_reg.waitreq;
	assign iack_hit = !cpu_as_n && cpu_fc == `IACK_FC
		&& cpu_addr[19:16] == `IACK_ADDR_HI; // [R3]
	assign iack_lvl = cpu_addr[3:1]; // [R3]

	always_comb begin
		case (address)
		`LOCAL_VEC_IDX:  rd_mux = {24'h000000, r_reg.lbase};
		`BUS_VEC_IDX:    rd_mux = {24'h000000, r_reg.bbase};
		`LOCAL_STAT_IDX: rd_mux = {20'h00000, local_stat};
		`LOCAL_MASK_IDX: rd_mux = {20'h00000, local_mask};
		`BUS_STAT_IDX:   rd_mux = {25'h0000000, bus_stat};
		`BUS_MASK_IDX:   rd_mux = {25'h0000000, bus_mask};
		`LOCAL_LVL_IDX:  rd_mux = {5'h00, r_reg.lvl_cfg};
		`VME_EN_IDX:     rd_mux = {25'h0000000, r_reg.vme_en};
		`CHAIN_STAT_IDX: rd_mux = {17'h0, r_reg.last_src,
			r_reg.st == ST_IDLE, r_reg.lvl, local_top, bus_top,
			vme_top};
		default:         rd_mux = 32'h00000000;
		endcase
	end

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb begin
		r_next = r_reg;
		// One wait cycle, then one cycle with waitrequest low
		r_next.waitreq = !(req && r_reg.waitreq);
		if (read && r_reg.waitreq) begin
			r_next.rdata = rd_mux;
		end
		if (take && write) begin
			case (address)
			`LOCAL_VEC_IDX: r_next.lbase = writedata[7:0];
			`BUS_VEC_IDX:   r_next.bbase = writedata[7:0];
			`LOCAL_LVL_IDX: r_next.lvl_cfg = writedata[26:0]; // [R2]
			`VME_EN_IDX:    r_next.vme_en = writedata[6:0];
			default:        r_next.lvl_cfg = r_reg.lvl_cfg;
			endcase
		end
		r_next.irq = |local_pend || |bus_pend;
		r_next.ipl_n = ~all_top;

		case (r_reg.st)
		ST_IDLE: begin
			if (iack_hit) begin
				r_next.lvl = iack_lvl;
				if (local_top == iack_lvl && local_top != 3'h0) begin
					r_next.vec = {r_reg.lbase[`LOCAL_BASE_MSB:
						`LOCAL_BASE_LSB], local_idx}; // [R4] [R9]
					r_next.dout = r_next.vec; // [R12]
					r_next.doe_n = 1'b0;
					r_next.dtack_n = 1'b0;
					r_next.last_src = 2'h1;
					r_next.st = ST_DONE;
				end else begin
					r_next.ack_out = 1'b1; // [R4] [R8]
					r_next.st = ST_CHAIN;
				end
			end
		end
		ST_CHAIN: begin
			if (cpu_as_n) begin
				r_next.ack_out = 1'b0;
				r_next.st = ST_IDLE;
			end else if (bus_top == r_reg.lvl && bus_top != 3'h0) begin
				r_next.vec = {r_reg.bbase[`BUS_BASE_MSB:`BUS_BASE_LSB],
					bus_idx + 3'h1}; // [R5] [R10]
				r_next.dout = r_next.vec; // [R12]
				r_next.doe_n = 1'b0;
				r_next.dtack_n = 1'b0;
				r_next.last_src = 2'h2;
				r_next.st = ST_DONE;
			end else if (vme_bus_held) begin
				r_next.vme_iack = 1'b1; // [R6]
				r_next.vme_lvl = r_reg.lvl;
				r_next.st = ST_VME_IACK;
			end else begin
				r_next.vme_req = 1'b1; // [R6]
				r_next.st = ST_VME_ARB;
			end
		end
		ST_VME_ARB: begin
			if (cpu_as_n) begin
				r_next.ack_out = 1'b0;
				r_next.vme_req = 1'b0;
				r_next.st = ST_IDLE;
			end else if (vme_bus_grant) begin
				r_next.vme_iack = 1'b1; // [R6]
				r_next.vme_lvl = r_reg.lvl;
				r_next.st = ST_VME_IACK;
			end
		end
		ST_VME_IACK: begin
			if (cpu_as_n) begin
				r_next.ack_out = 1'b0;
				r_next.vme_req = 1'b0;
				r_next.vme_iack = 1'b0;
				r_next.st = ST_IDLE;
			end else if (vme_dtack) begin
				r_next.vec = vme_vector; // [R7]
				r_next.dout = vme_vector; // [R12]
				r_next.doe_n = 1'b0;
				r_next.dtack_n = 1'b0;
				r_next.vme_req = 1'b0;
				r_next.vme_iack = 1'b0;
				r_next.last_src = 2'h3;
				r_next.st = ST_DONE;
			end
		end
		ST_DONE: begin
			// Hold the byte until the core ends its cycle
			if (cpu_as_n) begin
				r_next.doe_n = 1'b1; // [R12]
				r_next.dtack_n = 1'b1;
				r_next.dout = 8'h00;
				r_next.ack_out = 1'b0;
				r_next.st = ST_IDLE;
			end
		end
		default: begin
			r_next.st = ST_IDLE;
		end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			r_reg <= '0;
			r_reg.st <= ST_IDLE;
			r_reg.ipl_n <= 3'h7;
			r_reg.waitreq <= 1'b1;
			r_reg.doe_n <= 1'b1;
			r_reg.dtack_n <= 1'b1;
			r_reg.lbase <= `LOCAL_VEC_RST;
			r_reg.bbase <= `BUS_VEC_RST;
			r_reg.lvl_cfg <= `LOCAL_LVL_RST;
			r_reg.vme_en <= `VME_EN_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	assign readdata      = r_reg.rdata;
	assign waitrequest   = r_reg.waitreq;
	assign irq_out       = r_reg.irq;
	assign ipl_n         = r_reg.ipl_n;
	assign cpu_data_o    = r_reg.dout;
	assign cpu_data_oe_n = r_reg.doe_n;
	assign cpu_dtack_n   = r_reg.dtack_n;
	assign chain_ack_out = r_reg.ack_out;
	assign vme_bus_req   = r_reg.vme_req;
	assign vme_iack      = r_reg.vme_iack;
	assign vme_iack_lvl  = r_reg.vme_lvl;

	// ==========================================================
	// Checks
	// ==========================================================
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_idle_iack;
		r_reg.st == ST_IDLE && iack_hit;
	endsequence

	sequence s_local_match;
		s_idle_iack ##0 (local_top == iack_lvl && local_top != 3'h0);
	endsequence

	AST_IACK_DECODE: assert property ( // [R3]
		r_reg.st == ST_IDLE && !iack_hit |=> r_reg.st == ST_IDLE)
		else $error("idle left without acknowledge decode");
	AST_LOCAL_VECTOR: assert property ( // [R9]
		s_local_match |=> !cpu_dtack_n
		&& cpu_data_o[3:0] == $past(local_idx)
		&& cpu_data_o[7:4] == $past(r_reg.lbase[7:4]))
		else $error("local vector wrong");
	AST_CHAIN_OUT: assert property ( // [R4]
		s_idle_iack ##0 (local_top != iack_lvl) |=> chain_ack_out
			&& cpu_dtack_n)
		else $error("missing acknowledge out");
	AST_LOCAL_FIRST: assert property ( // [R8]
		s_local_match ##0 (bus_top == iack_lvl) |=> !chain_ack_out
			&& !cpu_data_oe_n)
		else $error("local chip lost priority");
	AST_BUS_VECTOR: assert property ( // [R10]
		r_reg.st == ST_CHAIN && !cpu_as_n && bus_top == r_reg.lvl
		&& bus_top != 3'h0 |=> cpu_data_o == {$past(r_reg.bbase[7:3]),
			$past(bus_top)})
		else $error("bus chip vector wrong");
	AST_VME_REQ: assert property ( // [R6]
		r_reg.st == ST_CHAIN && !cpu_as_n && bus_top != r_reg.lvl
		&& !vme_bus_held |=> vme_bus_req && !vme_iack)
		else $error("mastership not requested");
	AST_VME_LEVEL: assert property ( // [R6]
		vme_iack |-> vme_iack_lvl == iack_lvl && chain_ack_out)
		else $error("remote acknowledge level wrong");
	AST_FIXED_LEVEL: assert property ( // [R2]
		|local_pend[2:0] |-> local_top == `FIXED_LEVEL)
		else $error("fixed source not at level seven");
	AST_ABORT: assert property ( // [R11]
		$rose(local_src[2]) && local_mask[2] && $stable(local_mask)
		|-> ##2 ipl_n == 3'h0)
		else $error("abort did not raise level seven");
	AST_MASKED: assert property ( // [R1]
		local_pend == 12'h000 && bus_pend == 7'h00 |=> !irq_out)
		else $error("interrupt without enabled source");
	AST_DRIVE_PAIR: assert property ( // [R12]
		cpu_data_oe_n == cpu_dtack_n
		&& (!cpu_data_oe_n || cpu_data_o == 8'h00))
		else $error("vector drive and termination apart");
endmodule

// [bench/core_iack_model.sv]
`timescale 1ns/1ps
// =============================================================
// Core issuing acknowledge cycles, remote arbiter and interrupter
module core_iack_model #(
	parameter logic [4:0] REMOTE_BASE = 5'h16
) (
	input  wire logic        ref_clk,       // Clock
	input  wire logic        rst,           // Sync reset
	input  wire logic        slow,          // Remote side answers late
	output logic             cpu_as_n,      // Address strobe
	output logic      [2:0]  cpu_fc,        // Function code
	output logic      [19:1] cpu_addr,      // Address bus
	input  wire logic [7:0]  cpu_data_o,    // Vector byte
	input  wire logic        cpu_dtack_n,   // Termination
	input  wire logic        chain_ack_out, // Chain acknowledge
	input  wire logic        vme_bus_req,   // Bus request
	input  wire logic        vme_iack,      // Remote cycle
	input  wire logic [2:0]  vme_iack_lvl,  // Remote level
	output logic             vme_bus_grant, // Bus grant
	output logic      [7:0]  vme_vector,    // Remote vector
	output logic             vme_dtack      // Remote answer
);
	logic       saw_chain;
	logic       saw_req;
	logic       saw_viack;
	logic [2:0] viack_lvl;
	logic [2:0] gcnt;
	logic [2:0] dcnt;

	initial begin
		cpu_as_n = 1'b1;
		cpu_fc = 3'h0;
		cpu_addr = '0;
		vme_bus_grant = 1'b0;
		vme_vector = 8'h00;
		vme_dtack = 1'b0;
	end

	// Strobe held until termination, bounded so a dead cycle returns
	task automatic iack(input logic [2:0] fc, input logic [2:0] lvl,
			output logic [7:0] vec, output logic ok);
		logic [19:1] a;
		int          n;
		a = '0;
		a[19:16] = 4'hf;
		a[3:1] = lvl;
		n = 0;
		@(posedge ref_clk);
		saw_chain = 1'b0;
		saw_req = 1'b0;
		saw_viack = 1'b0;
		cpu_as_n <= 1'b0;
		cpu_fc <= fc;
		cpu_addr <= a;
		do begin
			@(posedge ref_clk);
			n++;
		end while (cpu_dtack_n !== 1'b0 && n < 16);
		vec = cpu_data_o;
		ok = (cpu_dtack_n === 1'b0);
		cpu_as_n <= 1'b1;
		cpu_fc <= 3'h0;
		repeat (3) @(posedge ref_clk);
	endtask

	always @(posedge ref_clk) begin
		if (chain_ack_out === 1'b1)
			saw_chain <= 1'b1;
		if (vme_bus_req === 1'b1)
			saw_req <= 1'b1;
		if (vme_iack === 1'b1) begin
			saw_viack <= 1'b1;
			viack_lvl <= vme_iack_lvl;
		end
		if (rst || vme_bus_req !== 1'b1) begin
			vme_bus_grant <= 1'b0;
			gcnt <= 3'h0;
		end else if (gcnt >= (slow ? 3'h4 : 3'h0)) begin
			vme_bus_grant <= 1'b1;
		end else begin
			gcnt <= gcnt + 3'h1;
		end
		// Idle vector toggles so a stale byte never passes
		if (rst || vme_iack !== 1'b1) begin
			vme_dtack <= 1'b0;
			dcnt <= 3'h0;
			vme_vector <= ~vme_vector;
		end else if (dcnt >= (slow ? 3'h4 : 3'h0)) begin
			vme_dtack <= 1'b1;
			vme_vector <= {REMOTE_BASE, vme_iack_lvl};
		end else begin
			dcnt <= dcnt + 3'h1;
			vme_vector <= ~vme_vector;
		end
	end
endmodule

// [bench/tb.sv]
`timescale 1ns/1ps
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin \
	err_count++; $display("MISMATCH %0t %s", $time, m); end end

module tb;
	localparam logic [4:0] RB = 5'h16;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  address = 4'h0;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [11:0] local_src = 12'h000;
	logic [6:0]  bus_src = 7'h00;
	logic [6:0]  vme_irq = 7'h00;
	logic        vme_bus_held = 1'b0;
	logic        slow = 1'b0;
	logic [31:0] readdata;
	logic        waitrequest, irq_out, cpu_data_oe_n, cpu_dtack_n;
	logic        chain_ack_out, vme_bus_req, vme_iack, cpu_as_n;
	logic        vme_bus_grant, vme_dtack;
	logic [2:0]  ipl_n, vme_iack_lvl, cpu_fc;
	logic [7:0]  cpu_data_o, vme_vector;
	logic [19:1] cpu_addr;
	int          err_count = 0;
	int          checks_done = 0;
	logic [31:0] rd;
	logic [7:0]  vec;
	logic        ok;

	always #5 ref_clk = ~ref_clk;

	interrupt_ack_vector_chain dut_u (
		.ref_clk, .rst, .address, .read, .write, .writedata, .readdata,
		.waitrequest, .irq_out, .local_src, .bus_src, .vme_irq, .cpu_as_n,
		.cpu_fc, .cpu_addr, .ipl_n, .cpu_data_o, .cpu_data_oe_n,
		.cpu_dtack_n, .chain_ack_out, .vme_bus_held, .vme_bus_grant,
		.vme_bus_req, .vme_iack, .vme_iack_lvl, .vme_vector, .vme_dtack
	);

	core_iack_model #(.REMOTE_BASE(RB)) core_u (
		.ref_clk, .rst, .slow, .cpu_as_n, .cpu_fc, .cpu_addr, .cpu_data_o,
		.cpu_dtack_n, .chain_ack_out, .vme_bus_req, .vme_iack,
		.vme_iack_lvl, .vme_bus_grant, .vme_vector, .vme_dtack
	);

	// ==========================================================
	// Bus and stimulus helpers
	task automatic bus_wr(input logic [3:0] idx, input logic [31:0] d);
		@(posedge ref_clk);
		address <= idx;
		writedata <= d;
		write <= 1'b1;
		do @(posedge ref_clk); while (waitrequest !== 1'b0);
		write <= 1'b0;
	endtask

	task automatic bus_rd(input logic [3:0] idx, output logic [31:0] d);
		@(posedge ref_clk);
		address <= idx;
		read <= 1'b1;
		do @(posedge ref_clk); while (waitrequest !== 1'b0);
		d = readdata;
		read <= 1'b0;
	endtask

	// Status lands one edge after the pulse rises; three keeps margin
	task automatic pulse(input logic [11:0] l, input logic [6:0] b);
		@(posedge ref_clk);
		local_src <= l;
		bus_src <= b;
		@(posedge ref_clk);
		local_src <= 12'h000;
		bus_src <= 7'h00;
		repeat (3) @(posedge ref_clk);
	endtask

	task automatic ack(input logic [2:0] lvl, input logic [7:0] exp,
			input logic chain);
		core_u.iack(3'h7, lvl, vec, ok);
		`CHK(ok, 1'b1, "acknowledge not terminated")
		`CHK(vec, exp, "vector")
		`CHK(core_u.saw_chain, chain, "chain pass")
		`CHK(cpu_data_oe_n, 1'b1, "data not released")
	endtask

	task automatic end_of_test;
		if (err_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs;
		bus_rd(4'h0, rd);
		`CHK(rd, 32'h0, "local base reset")
		bus_rd(4'h1, rd);
		`CHK(rd, 32'h0, "bus base reset")
		bus_wr(4'h0, 32'ha5);
		bus_wr(4'h1, 32'h9f);
		bus_wr(4'hc, 32'hff);
		bus_rd(4'h0, rd);
		`CHK(rd, 32'ha5, "local base")
		bus_rd(4'h1, rd);
		`CHK(rd, 32'h9f, "bus base")
		bus_rd(4'hc, rd);
		`CHK(rd, 32'h0, "unmapped read")
	endtask

	task automatic t_abort;
		pulse(12'h004, 7'h00);
		bus_rd(4'h2, rd);
		`CHK(rd[2], 1'b1, "abort status")
		`CHK(irq_out, 1'b0, "disabled abort")
		`CHK(ipl_n, 3'h7, "disabled abort level")
		bus_wr(4'h3, 32'h4);
		repeat (3) @(posedge ref_clk);
		`CHK(irq_out, 1'b1, "abort irq")
		`CHK(ipl_n, 3'h0, "abort level")
		core_u.iack(3'h5, 3'h7, vec, ok);
		`CHK(ok, 1'b0, "wrong function code")
		ack(3'h7, 8'ha2, 1'b0);
		bus_wr(4'h2, 32'h4);
		repeat (3) @(posedge ref_clk);
		`CHK(irq_out, 1'b0, "abort cleared")
		`CHK(ipl_n, 3'h7, "level cleared")
	endtask

	// Programmable sources at five; first three must stay at seven
	task automatic t_local_all;
		bus_wr(4'h6, {5'h00, 27'o555555555});
		bus_wr(4'h3, 32'hfff);
		for (int i = 0; i < 12; i++) begin
			pulse(12'h001 << i, 7'h00);
			ack((i < 3) ? 3'h7 : 3'h5, {4'ha, i[3:0]}, 1'b0);
			bus_wr(4'h2, 32'h1 << i);
		end
	endtask

	task automatic t_bus_all;
		bus_wr(4'h5, 32'h7f);
		for (int c = 1; c < 8; c++) begin
			pulse(12'h000, 7'h01 << (c - 1));
			ack(c[2:0], {5'h13, c[2:0]}, 1'b1);
			`CHK(core_u.saw_req, 1'b0, "bus chip went remote")
			bus_wr(4'h4, 32'h1 << (c - 1));
		end
	endtask

	task automatic t_prio;
		bus_wr(4'h7, 32'h10);
		@(posedge ref_clk);
		vme_irq <= 7'h10;
		pulse(12'h010, 7'h10);
		ack(3'h5, 8'ha4, 1'b0);
		bus_wr(4'h2, 32'h10);
		repeat (3) @(posedge ref_clk);
		ack(3'h5, 8'h9d, 1'b1);
		`CHK(core_u.saw_viack, 1'b0, "remote beat bus chip")
		bus_wr(4'h4, 32'h10);
		repeat (3) @(posedge ref_clk);
		ack(3'h5, {RB, 3'h5}, 1'b1);
		`CHK(core_u.saw_req, 1'b1, "no bus request")
		`CHK(core_u.viack_lvl, 3'h5, "remote level")
		bus_rd(4'h8, rd);
		`CHK(rd, 32'h00007a05, "chain status")
	endtask

	task automatic t_remote_held;
		@(posedge ref_clk);
		slow <= 1'b1;
		vme_bus_held <= 1'b1;
		vme_irq <= 7'h02;
		bus_wr(4'h7, 32'h02);
		repeat (3) @(posedge ref_clk);
		ack(3'h2, {RB, 3'h2}, 1'b1);
		`CHK(core_u.saw_req, 1'b0, "request while held")
		`CHK(core_u.viack_lvl, 3'h2, "held remote level")
		@(posedge ref_clk);
		vme_irq <= 7'h00;
		vme_bus_held <= 1'b0;
	endtask

	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		t_regs;
		t_abort;
		t_local_all;
		t_bus_all;
		t_prio;
		t_remote_held;
		end_of_test;
	end

	// Whole run needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		end_of_test;
	end
endmodule
